// ---- bench/data_address_map_test.sv ----
`timescale 1ns/1ps
module data_address_map_test;
  import addr_map_pkg::*;
  logic clk, rst_b, cmp_true, ram_block_placement_bit;
  logic [2:0] pointer_select_field;
  ptr_op_t ptr_op;
  cmp_op_t cmp_op;
  logic [15:0] ptr_load_value, acc_direct_addr, acc_wdata, acc_rdata, cur_pointer;
  logic [7:0] global_allocation_register;
  logic acc_req, acc_prog, acc_write, acc_indirect, acc_done, acc_busy;
  logic global_space_request, ext_write, ext_ready;
  logic [15:0] ext_addr, ext_wdata, ext_rdata, rd, v, g;
  logic [3:0] wait_cycles;
  logic [15:0] ptr [8] = '{default: 16'h0000}; // expected pointer contents
  logic [15:0] alist [12] = '{16'h0060, 16'h007F, 16'h0300, 16'h03FF, 16'h0200, 16'h02FF,
    16'h005F, 16'h0080, 16'h0400, 16'h01FF, 16'hFF00, 16'hFFFF};
  logic [31:0] seed = 32'hC48027AA;
  int bad_count = 0, comparisons = 0, cycles = 0, n;
  data_address_map data_address_map_inst (.clk, .rst_b, .pointer_select_field, .ptr_op,
    .ptr_load_value, .cmp_op, .cmp_true, .ram_block_placement_bit, .global_allocation_register,
    .acc_req, .acc_prog, .acc_write, .acc_direct_addr, .acc_indirect, .acc_wdata, .acc_done,
    .acc_rdata, .acc_busy, .cur_pointer, .global_space_request, .ext_addr, .ext_wdata,
    .ext_write, .ext_rdata, .ext_ready);
  global_mem_model global_mem_model_inst (.clk, .wait_cycles, .global_space_request,
    .ext_addr, .ext_wdata, .ext_write, .ext_rdata, .ext_ready);
  // fixed-seed generator so a failing run repeats exactly
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed[15:0];
  endfunction
  // unsigned compare against pointer zero
  function automatic logic cmp_want(input cmp_op_t c, input logic [15:0] a, input logic [15:0] b);
    case (c)
      CMP_EQ: return a == b;
      CMP_LT: return a < b;
      CMP_GT: return a > b;
      default: return a != b;
    endcase
  endfunction
  // which place answers: fixed blocks in data only, movable one follows the bit
  function automatic logic mapped(input logic p, input logic prog, input logic [15:0] a);
    if (prog)
      return p && a >= 16'hFF00;
    return (a >= 16'h0060 && a <= 16'h007F) || (a >= 16'h0300 && a <= 16'h03FF) ||
      (!p && a >= 16'h0200 && a <= 16'h02FF);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic ptr_do(input logic [2:0] s, input ptr_op_t op, input logic [15:0] val);
    pointer_select_field = s;
    ptr_op = op;
    ptr_load_value = val;
    step();
    ptr_op = OP_NONE;
    case (op)
      OP_INC: ptr[s] = ptr[s] + 16'h0001;
      OP_DEC: ptr[s] = ptr[s] - 16'h0001;
      OP_ADD_IDX: ptr[s] = ptr[s] + ptr[0];
      OP_SUB_IDX: ptr[s] = ptr[s] - ptr[0];
      OP_LOAD: ptr[s] = val;
      default: ;
    endcase
    check(cur_pointer, ptr[s]);
  endtask
  // on-chip request stands one edge; global one is held until done, bus checked each cycle
  task automatic access(input logic prog, input logic wr, input logic [15:0] a,
      input logic [15:0] wd, input logic glob, input logic ind, output logic [15:0] r);
    int k;
    k = 0;
    acc_prog = prog;
    acc_write = wr;
    acc_indirect = ind;
    acc_direct_addr = ind ? ~a : a;
    acc_wdata = wd;
    acc_req = 1'b1;
    do begin
      step();
      k++;
      if (!glob) acc_req = 1'b0; // on-chip requests are taken at their first edge
      if (!acc_done) check({15'h0, global_space_request}, {15'h0, glob});
      if (!acc_done) check({15'h0, acc_busy}, {15'h0, glob});
      if (!acc_done && glob) check(ext_addr, a);
    end while (!acc_done && k < 40);
    check({15'h0, acc_done}, 16'h0001);
    check({15'h0, global_space_request}, 16'h0000);
    if (!glob) check(k[15:0], 16'h0002);
    r = acc_rdata;
    acc_req = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the under one thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 8000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    {rst_b, acc_req, acc_prog, acc_write, acc_indirect, ram_block_placement_bit} = 6'h00;
    {pointer_select_field, ptr_load_value, acc_direct_addr, acc_wdata} = 51'h0;
    {global_allocation_register, wait_cycles} = 12'h000;
    ptr_op = OP_NONE;
    cmp_op = CMP_EQ;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 8; i++) ptr_do(3'(i), OP_LOAD, rnd());
    ptr_do(1, OP_LOAD, 16'hFFFF);
    ptr_do(1, OP_INC, 16'h0000);
    ptr_do(1, OP_DEC, 16'h0000);
    ptr_do(2, OP_LOAD, ptr[0]);
    for (int i = 0; i < 40; i++) ptr_do(3'(rnd()), ptr_op_t'(rnd() % 16'd6), rnd());
    ptr_do(3, OP_LOAD, ptr[0]);
    for (int i = 0; i < 32; i++) begin
      pointer_select_field = 3'(i);
      cmp_op = cmp_op_t'(i / 8);
      step();
      check({15'h0, cmp_true}, {15'h0, cmp_want(cmp_op, ptr[i % 8], ptr[0])});
    end
    // write every place first, then read, so a wrong alias shows up
    for (int p = 0; p < 2; p++) begin
      ram_block_placement_bit = 1'(p);
      for (int w = 1; w >= 0; w--)
        for (int s = 0; s < 24; s++) begin
          v = alist[s % 12] ^ (s < 12 ? 16'h0F0F : 16'hF0F0) ^ 16'(p);
          access(s >= 12, 1'(w), alist[s % 12], v, 0, 0, rd);
          if (!w) check(rd, mapped(1'(p), s >= 12, alist[s % 12]) ? v : 16'h0000);
        end
    end
    ptr_do(5, OP_LOAD, 16'h03FF);
    access(0, 0, 16'h03FF, 0, 0, 1, rd);
    check(rd, 16'h03FF ^ 16'h0F0F ^ 16'h0001);
    for (int i = 0; i < 12; i++) begin
      global_allocation_register = (i == 0) ? 8'h80 : (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : 8'(rnd());
      wait_cycles = 4'(rnd());
      n = (global_allocation_register > 8'h80 ? 128 : global_allocation_register) * 256;
      g = 16'(65536 - n);
      if (n == 0) begin
        access(0, 0, 16'hFFFF, 0, 0, 0, rd);
        check(rd, 16'h0000);
      end else begin
        v = rnd();
        access(0, 1, g, v, 1, 0, rd);
        step();
        access(0, 0, g, 0, 1, 0, rd);
        check(rd, v);
        step();
        access(0, 0, g - 16'h0001, 0, 0, 0, rd);
        check(rd, 16'h0000);
      end
    end
    // mid-run reset: pointers and request return to their idle values
    rst_b = 1'b0;
    step();
    check(cur_pointer, 16'h0000);
    check({15'h0, global_space_request}, 16'h0000);
    rst_b = 1'b1;
    step();
    check({15'h0, acc_done}, 16'h0000);
    end_sim();
  end
endmodule

// ---- bench/global_mem_model.sv ----
`timescale 1ns/1ps
// far-side global data memory; answers after a chosen number of cycles
module global_mem_model (
  input wire logic clk,
  input wire logic [3:0] wait_cycles,
  input wire logic global_space_request,
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_wdata,
  input wire logic ext_write,
  output logic [15:0] ext_rdata,
  output logic ext_ready
);
  logic [15:0] mem [logic [15:0]]; // sparse storage, only touched words
  int count = 0; // cycles the request has waited
  initial begin
    ext_ready = 1'b0;
    ext_rdata = 16'h0000;
  end
  // ready only once the chosen latency has run out; data bus is inverted each cycle it is not answering
  always @(posedge clk) begin
    #1;
    if (!global_space_request) begin
      count = 0;
      ext_ready = 1'b0;
      ext_rdata = ~ext_rdata;
    end else if (count < wait_cycles) begin
      count++;
      ext_rdata = ~ext_rdata;
    end else if (!ext_ready) begin
      ext_ready = 1'b1;
      if (ext_write)
        mem[ext_addr] = ext_wdata;
      else
        ext_rdata = mem.exists(ext_addr) ? mem[ext_addr] : 16'h0000;
    end
  end
endmodule

// ---- logic/data_address_map.sv ----
`timescale 1ns/1ps
`include "addr_map_params.svh"
// Contract
// - unsigned 16-bit address unit updates pointers
// - eight 16-bit pointer registers
// - selected pointer chosen by select field
// - pointer zero steps another pointer
// - pointer zero is compare operand
// - placement bit moves block data/program
// - fixed blocks at 0300-03FF, 0060-007F only
// - block sizes 256, 256, 32 words
// - request asserted throughout global access
// - global space up to 32K words
// - allocation register sets global size
module data_address_map (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] pointer_select_field,
  input wire addr_map_pkg::ptr_op_t ptr_op,
  input wire logic [15:0] ptr_load_value,
  input wire addr_map_pkg::cmp_op_t cmp_op,
  output logic cmp_true,
  input wire logic ram_block_placement_bit,
  input wire logic [7:0] global_allocation_register,
  input wire logic acc_req,
  input wire logic acc_prog,
  input wire logic acc_write,
  input wire logic [15:0] acc_direct_addr,
  input wire logic acc_indirect,
  input wire logic [15:0] acc_wdata,
  output logic acc_done,
  output logic [15:0] acc_rdata,
  output logic acc_busy,
  output logic [15:0] cur_pointer,
  output logic global_space_request,
  output logic [15:0] ext_addr,
  output logic [15:0] ext_wdata,
  output logic ext_write,
  input wire logic [15:0] ext_rdata,
  input wire logic ext_ready
);
  import addr_map_pkg::*;

  // state of the external global access
  typedef enum logic [1:0] {
    G_IDLE,
    G_WAIT,
    G_DONE
  } gstate_t;

  // pointer file, each may point anywhere in data space
  logic [15:0] pointer_registers [8];
  logic [15:0] index_compare_pointer;
  logic [15:0] sel_ptr;
  logic [15:0] next_ptr;
  logic [15:0] acc_addr;
  hit_t hit;
  gstate_t gstate;
  // ready pin synchronisers
  logic ready_s1;
  logic ready_s2;
  // read data pin stages, kept in step with the ready stages
  logic [15:0] rdata_s1;
  logic [15:0] rdata_s2;
  // internal read pipeline
  logic rd_pend;
  hit_t rd_hit;
  logic [15:0] rd_big;
  logic [15:0] rd_small;
  logic [15:0] rd_move;

  // global window size in words; the value saturates at 32K
  function automatic logic [16:0] global_words(input logic [7:0] alloc);
    logic [16:0] w;
    w = {1'b0, alloc, 8'h00};
    if (w > 17'(`GLOBAL_MAX_WORDS)) begin
      w = 17'(`GLOBAL_MAX_WORDS);
    end
    return w;
  endfunction

  // classify an address into one of the memories
  function automatic hit_t classify(input logic [15:0] a, input logic prog,
                                    input logic place, input logic [7:0] alloc);
    logic [16:0] gbase;
    gbase = 17'h10000 - global_words(alloc);
    if (prog) begin
      // program space: only the movable block when placed there
      if (place && a >= `MOVE_PROG_BASE) return HIT_MOVABLE;
      return HIT_NONE;
    end
    if (a >= `BIG_BASE && a <= `BIG_LAST) return HIT_BIG;
    if (a >= `SMALL_BASE && a <= `SMALL_LAST) return HIT_SMALL;
    if (!place && a >= `MOVE_DATA_BASE && a < `BIG_BASE) return HIT_MOVABLE;
    if (alloc != 8'h00 && {1'b0, a} >= gbase) return HIT_GLOBAL;
    return HIT_NONE;
  endfunction

  // selected pointer and pointer zero
  assign sel_ptr = pointer_registers[pointer_select_field];
  assign index_compare_pointer = pointer_registers[0];
  assign cur_pointer = sel_ptr;
  assign acc_addr = acc_indirect ? sel_ptr : acc_direct_addr;
  assign hit = classify(acc_addr, acc_prog, ram_block_placement_bit,
                        global_allocation_register);

  // next pointer value, unsigned modulo 2^16
  always_comb begin
    unique case (ptr_op)
      OP_NONE: next_ptr = sel_ptr;
      OP_INC: next_ptr = 16'(sel_ptr + 16'h0001);
      OP_DEC: next_ptr = 16'(sel_ptr - 16'h0001);
      OP_ADD_IDX: next_ptr = 16'(sel_ptr + index_compare_pointer);
      OP_SUB_IDX: next_ptr = 16'(sel_ptr - index_compare_pointer);
      OP_LOAD: next_ptr = ptr_load_value;
      default: next_ptr = sel_ptr; // spare op codes leave it alone
    endcase
  end

  // pointer writeback; held off while a global access stalls
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) begin
        pointer_registers[i] <= `PTR_RESET;
      end
    end else if (!acc_busy) begin
      pointer_registers[pointer_select_field] <= next_ptr;
    end
  end

  // unsigned compare of selected pointer against pointer zero
  always_comb begin
    unique case (cmp_op)
      CMP_EQ: cmp_true = (sel_ptr == index_compare_pointer);
      CMP_LT: cmp_true = (sel_ptr < index_compare_pointer);
      CMP_GT: cmp_true = (sel_ptr > index_compare_pointer);
      CMP_NE: cmp_true = (sel_ptr != index_compare_pointer);
    endcase
  end

  // the ready pin is asynchronous, two flops before use
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_s1 <= 1'b0;
      ready_s2 <= 1'b0;
    end else begin
      ready_s1 <= ext_ready;
      ready_s2 <= ready_s1;
    end
  end

  // read data from the far side passes two flops as well; the memory must
  // hold it steady while ready stands, so the second stage lines up with ready_s2
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_s1 <= 16'h0000;
      rdata_s2 <= 16'h0000;
    end else begin
      rdata_s1 <= ext_rdata;
      rdata_s2 <= rdata_s1;
    end
  end

  // global access: request held with stable address until ready
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gstate <= G_IDLE;
      global_space_request <= 1'b0;
      ext_addr <= 16'h0000;
      ext_wdata <= 16'h0000;
      ext_write <= 1'b0;
    end else begin
      unique case (gstate)
        G_IDLE: begin
          if (acc_req && hit == HIT_GLOBAL) begin
            gstate <= G_WAIT;
            global_space_request <= 1'b1;
            ext_addr <= acc_addr;
            ext_wdata <= acc_wdata;
            ext_write <= acc_write;
          end
        end
        G_WAIT: begin
          // address and strobes stay frozen here
          if (ready_s2) begin
            gstate <= G_DONE;
            global_space_request <= 1'b0;
            ext_write <= 1'b0;
          end
        end
        G_DONE: begin
          gstate <= G_IDLE;
        end
      endcase
    end
  end

  // the core must stall while a global access is open
  assign acc_busy = (gstate == G_WAIT) || (gstate == G_IDLE && acc_req && hit == HIT_GLOBAL);

  // on-chip blocks, sizes fixed
  dual_ram #(.WORDS(`MOVE_WORDS), .AW(8)) u_movable_ram_block (
    .clk(clk),
    .wr(acc_req && acc_write && hit == HIT_MOVABLE),
    .addr(acc_addr[7:0]),
    .wdata(acc_wdata),
    .rdata(rd_move)
  );
  dual_ram #(.WORDS(`BIG_WORDS), .AW(8)) u_first_fixed_ram_block (
    .clk(clk),
    .wr(acc_req && acc_write && hit == HIT_BIG),
    .addr(acc_addr[7:0]),
    .wdata(acc_wdata),
    .rdata(rd_big)
  );
  dual_ram #(.WORDS(`SMALL_WORDS), .AW(5)) u_second_fixed_ram_block (
    .clk(clk),
    .wr(acc_req && acc_write && hit == HIT_SMALL),
    .addr(acc_addr[4:0]),
    .wdata(acc_wdata),
    .rdata(rd_small)
  );

  // completion tracking for on-chip and unmapped accesses
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend <= 1'b0;
      rd_hit <= HIT_NONE;
    end else begin
      rd_pend <= acc_req && hit != HIT_GLOBAL;
      rd_hit <= hit;
    end
  end

  // answer: two cycles after request on chip, after ready for global
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_done <= 1'b0;
      acc_rdata <= 16'h0000;
    end else begin
      acc_done <= 1'b0;
      if (gstate == G_WAIT && ready_s2) begin
        acc_done <= 1'b1;
        acc_rdata <= rdata_s2;
      end else if (rd_pend) begin
        acc_done <= 1'b1;
        unique case (rd_hit)
          HIT_MOVABLE: acc_rdata <= rd_move;
          HIT_BIG: acc_rdata <= rd_big;
          HIT_SMALL: acc_rdata <= rd_small;
          default: acc_rdata <= 16'h0000; // unmapped reads as zero
        endcase
      end
    end
  end

  // request stays high while waiting for ready
  a_req_held: assert property (@(posedge clk) disable iff (!rst_b)
    gstate == G_WAIT |-> global_space_request)
    else $error("request dropped while waiting");
  a_addr_stable: assert property (@(posedge clk) disable iff (!rst_b)
    global_space_request && !$past(ready_s2) && $past(global_space_request)
      |-> $stable(ext_addr) && $stable(ext_write))
    else $error("global address moved during wait");
  a_done_after_ready: assert property (@(posedge clk) disable iff (!rst_b)
    gstate == G_WAIT && ready_s2 |=> acc_done && !global_space_request)
    else $error("global access not completed on ready");
  a_fixed_not_prog: assert property (@(posedge clk) disable iff (!rst_b)
    acc_prog |-> hit != HIT_BIG && hit != HIT_SMALL)
    else $error("fixed block decoded in program space");
  a_move_place: assert property (@(posedge clk) disable iff (!rst_b)
    hit == HIT_MOVABLE |-> acc_prog == ram_block_placement_bit)
    else $error("movable block in wrong space");
  a_ptr_inc: assert property (@(posedge clk) disable iff (!rst_b)
    ptr_op == OP_INC && !acc_busy |=>
      pointer_registers[$past(pointer_select_field)] == 16'($past(sel_ptr) + 16'h0001))
    else $error("pointer increment wrong");
  a_ptr_index: assert property (@(posedge clk) disable iff (!rst_b)
    ptr_op == OP_ADD_IDX && !acc_busy && pointer_select_field != 3'h0 |=>
      pointer_registers[$past(pointer_select_field)]
        == 16'($past(sel_ptr) + $past(index_compare_pointer)))
    else $error("index step wrong");
  a_cmp_eq: assert property (@(posedge clk) disable iff (!rst_b)
    cmp_op == CMP_EQ |-> cmp_true == (sel_ptr == pointer_registers[0]))
    else $error("compare against pointer zero wrong");
  a_global_size: assert property (@(posedge clk) disable iff (!rst_b)
    global_allocation_register == 8'h00 |-> hit != HIT_GLOBAL)
    else $error("global hit with no global space");
  a_onchip_done: assert property (@(posedge clk) disable iff (!rst_b)
    acc_req && hit != HIT_GLOBAL |-> ##2 acc_done)
    else $error("on-chip access not answered");
  // the core stays stalled for the whole global wait
  a_busy_wait: assert property (@(posedge clk) disable iff (!rst_b)
    gstate == G_WAIT |-> acc_busy)
    else $error("core not stalled during global wait");

  c_global: cover property (@(posedge clk) disable iff (!rst_b)
    gstate == G_WAIT ##1 gstate == G_WAIT ##1 gstate == G_DONE);
  c_move_prog: cover property (@(posedge clk) disable iff (!rst_b)
    acc_req && hit == HIT_MOVABLE && acc_prog);
  c_small: cover property (@(posedge clk) disable iff (!rst_b)
    acc_req && hit == HIT_SMALL && acc_indirect);
  c_index: cover property (@(posedge clk) disable iff (!rst_b)
    ptr_op == OP_ADD_IDX && !acc_busy);
  c_unmapped: cover property (@(posedge clk) disable iff (!rst_b)
    acc_req && hit == HIT_NONE && !acc_prog);
endmodule

// ---- logic/dual_ram.sv ----
`timescale 1ns/1ps
// single dual-access block: one write port, one registered read port
module dual_ram #(
  parameter int WORDS = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic wr,
  input wire logic [AW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  // storage; no reset, contents are undefined after power-up
  logic [15:0] mem [WORDS];

  // write port
  always_ff @(posedge clk) begin
    if (wr) begin
      mem[addr] <= wdata;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end
endmodule

// ---- shared/addr_map_params.svh ----
`ifndef ADDR_MAP_PARAMS_SVH
`define ADDR_MAP_PARAMS_SVH
// address and data width of the data space
`define AW 16
// second fixed block window, 32 words
`define SMALL_BASE 16'h0060
`define SMALL_LAST 16'h007F
`define SMALL_WORDS 32
// first fixed block window, 256 words
`define BIG_BASE 16'h0300
`define BIG_LAST 16'h03FF
`define BIG_WORDS 256
// movable block windows in data and program space
`define MOVE_DATA_BASE 16'h0200
`define MOVE_PROG_BASE 16'hFF00
`define MOVE_WORDS 256
// pointer reset value
`define PTR_RESET 16'h0000
// allocation register reset value, no global space
`define GLOBAL_ALLOC_RESET 8'h00
// largest global window, 32K words
`define GLOBAL_MAX_WORDS 32768
`endif

// ---- shared/addr_map_pkg.sv ----
package addr_map_pkg;
  // pointer update operations
  typedef enum logic [2:0] {
    OP_NONE,
    OP_INC,
    OP_DEC,
    OP_ADD_IDX,
    OP_SUB_IDX,
    OP_LOAD
  } ptr_op_t;
  // which memory an access lands in
  typedef enum logic [2:0] {
    HIT_NONE,
    HIT_MOVABLE,
    HIT_BIG,
    HIT_SMALL,
    HIT_GLOBAL
  } hit_t;
  // compare operations against pointer zero
  typedef enum logic [1:0] {
    CMP_EQ,
    CMP_LT,
    CMP_GT,
    CMP_NE
  } cmp_op_t;
endpackage
